// File: inc/mci_consts.vh
// constants for the motion command interpreter
`ifndef MCI_CONSTS_VH
`define MCI_CONSTS_VH
`define MCI_OP_ROTR        8'h01
`define MCI_OP_ROTL        8'h02
`define MCI_OP_STOP        8'h03
`define MCI_OP_SET_GLOBAL  8'h09
`define MCI_OP_IRQ_EN      8'h19
`define MCI_OP_DI          8'h1A
`define MCI_OP_HANDLER_ADDR 8'h25
`define MCI_OP_HANDLER_RET 8'h26
`define MCI_BANK_IRQ       8'h03
`define MCI_PARAM_TVEL     8'h02
`define MCI_PARAM_TSPD     8'h00
`define MCI_ST_OK          8'h64
`define MCI_ST_BADSUM      8'h01
`define MCI_ST_BADCMD      8'h02
`define MCI_IRQ_GLOBAL     8'hFF
`define MCI_IRQ_COUNT      42
`define MCI_FRAME_LEN      9
`define MCI_ADDR_RESET     8'h01
`endif

// File: logic/mci_vector_mem.v
// handler vector memory with registered read
`timescale 1ns/1ns
`default_nettype none
module mci_vector_mem #(
    parameter AW = 6,
    parameter DW = 32
) (
    input  wire          ref_clk,
    input  wire          wrEn,
    input  wire [AW-1:0] wrAddr,
    input  wire [DW-1:0] wrData,
    input  wire [AW-1:0] rdAddr,
    output reg  [DW-1:0] rdData_q
);
    reg [DW-1:0] mem [0:(1<<AW)-1];  // storage words

    // write port and registered read
    always @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData_q <= mem[rdAddr];
    end
endmodule
`default_nettype wire

// File: logic/mci_top.v
// motion command frame decoder with interrupt control
`timescale 1ns/1ns
`default_nettype none
`include "mci_consts.vh"
module mci_top (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        rxValid,       // frame byte strobe
    input  wire [7:0]  rxByte,        // frame byte
    input  wire [7:0]  moduleAddr,    // own target address
    input  wire [41:0] irqEvent,      // interrupt source pulses
    input  wire [31:0] accIn,         // live accumulator
    input  wire [31:0] xIn,           // live x register
    input  wire [7:0]  flagsIn,       // live flags
    input  wire [31:0] pcIn,          // live program counter
    output reg         velModeSel_q,  // velocity mode select pulse
    output reg         paramWr_q,     // axis parameter write pulse
    output reg  [7:0]  paramNum_q,    // axis parameter number
    output reg  [31:0] paramVal_q,    // axis parameter value
    output reg         dirPositive_q, // rotation direction
    output reg         replyValid_q,  // reply strobe
    output reg  [7:0]  replyStatus_q, // reply status
    output reg  [31:0] replyValue_q,  // reply value
    output reg         irqEnter_q,    // handler entry pulse
    output reg  [31:0] irqVector_q,   // handler entry address
    output reg         irqReturn_q,   // context restore pulse
    output reg  [31:0] accOut_q,      // restored accumulator
    output reg  [31:0] xOut_q,        // restored x register
    output reg  [7:0]  flagsOut_q,    // restored flags
    output reg  [31:0] pcOut_q,       // resume address
    output reg         inHandler_q,   // handler running
    output reg         cfgWr_q,       // irq setting write pulse
    output reg  [7:0]  cfgIrq_q,      // irq setting number
    output reg  [31:0] cfgVal_q       // irq setting value
);
    localparam NIRQ = `MCI_IRQ_COUNT;
    localparam S_IDLE = 2'd0;
    localparam S_VEL  = 2'd1;
    localparam S_ARM  = 2'd2;
    localparam S_FIRE = 2'd3;

    reg [3:0]      cnt_q;                // frame byte index
    reg [7:0]      sum_q;                // running checksum
    reg [7:0]      fAddr_q, fOp_q, fType_q, fBank_q;
    reg [31:0]     fVal_q;               // value field
    reg            frameDone_q;          // full frame received
    reg [7:0]      fSum_q;               // received checksum
    reg [1:0]      st_q;                 // sequencer state
    reg [NIRQ-1:0] pend_q;               // pending sources
    reg [NIRQ-1:0] en_q;                 // per-source enable
    reg [NIRQ-1:0] vecOk_q;              // vector defined
    reg            gEn_q;                // global enable
    reg [5:0]      sel_q;                // source being serviced
    reg [31:0]     sAcc_q, sX_q, sPc_q;  // saved context
    reg [7:0]      sFlags_q;
    wire [31:0]    vecData;              // vector read data

    // true for an implemented irq number, which doubles as its table index
    function valid_irq;
        input [7:0] n;
        begin
            valid_irq = (n <= 8'd3) || (n == 8'd15) || (n == 8'd21) || (n == 8'd27)
                || (n == 8'd28) || (n >= 8'd39 && n <= 8'd41);
        end
    endfunction

    // lowest ready source
    reg [5:0] pick;
    reg       anyReady;
    integer   i;
    always @* begin
        pick = 6'd0;
        anyReady = 1'b0;
        for (i = NIRQ - 1; i >= 0; i = i - 1) begin
            if (pend_q[i] && en_q[i] && vecOk_q[i]) begin
                pick = i[5:0];
                anyReady = 1'b1;
            end
        end
    end

    wire vecWr = frameDone_q && (sum_q == fSum_q) && (fAddr_q == moduleAddr)
                 && (fOp_q == `MCI_OP_HANDLER_ADDR) && valid_irq(fType_q);

    mci_vector_mem #(.AW(6), .DW(32)) uVec (
        .ref_clk  (ref_clk),
        .wrEn     (vecWr),
        .wrAddr   (fType_q[5:0]),
        .wrData   (fVal_q),
        .rdAddr   (sel_q),
        .rdData_q (vecData)
    );

    // frame byte collection and checksum
    always @(posedge ref_clk) begin
        if (rst) begin
            cnt_q <= 4'd0;
            sum_q <= 8'h00;
            fAddr_q <= 8'h00;
            fOp_q <= 8'h00;
            fType_q <= 8'h00;
            fBank_q <= 8'h00;
            fVal_q <= 32'h00000000;
            fSum_q <= 8'h00;
            frameDone_q <= 1'b0;
        end else begin
            frameDone_q <= 1'b0;
            if (rxValid) begin
                case (cnt_q)
                    4'd0: fAddr_q <= rxByte;
                    4'd1: fOp_q <= rxByte;
                    4'd2: fType_q <= rxByte;
                    4'd3: fBank_q <= rxByte;
                    4'd4, 4'd5, 4'd6, 4'd7: fVal_q <= {fVal_q[23:0], rxByte};
                    default: fSum_q <= rxByte;
                endcase
                if (cnt_q == 4'd8) begin
                    cnt_q <= 4'd0;
                    frameDone_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 4'd1;
                    sum_q <= ((cnt_q == 4'd0) ? 8'h00 : sum_q) + rxByte;
                end
            end
        end
    end

    // command execution, reply and interrupt control
    always @(posedge ref_clk) begin
        if (rst) begin
            st_q <= S_IDLE;
            velModeSel_q <= 1'b0;
            paramWr_q <= 1'b0;
            paramNum_q <= 8'h00;
            paramVal_q <= 32'h00000000;
            dirPositive_q <= 1'b1;
            replyValid_q <= 1'b0;
            replyStatus_q <= 8'h00;
            replyValue_q <= 32'h00000000;
            irqEnter_q <= 1'b0;
            irqVector_q <= 32'h00000000;
            irqReturn_q <= 1'b0;
            accOut_q <= 32'h00000000;
            xOut_q <= 32'h00000000;
            flagsOut_q <= 8'h00;
            pcOut_q <= 32'h00000000;
            inHandler_q <= 1'b0;
            cfgWr_q <= 1'b0;
            cfgIrq_q <= 8'h00;
            cfgVal_q <= 32'h00000000;
            pend_q <= {NIRQ{1'b0}};
            en_q <= {NIRQ{1'b0}};
            vecOk_q <= {NIRQ{1'b0}};
            gEn_q <= 1'b0;
            sel_q <= 6'd0;
            sAcc_q <= 32'h00000000;
            sX_q <= 32'h00000000;
            sPc_q <= 32'h00000000;
            sFlags_q <= 8'h00;
        end else begin
            velModeSel_q <= 1'b0;
            paramWr_q <= 1'b0;
            replyValid_q <= 1'b0;
            irqEnter_q <= 1'b0;
            irqReturn_q <= 1'b0;
            cfgWr_q <= 1'b0;
            // sticky pend: new event wins over service clear
            pend_q <= pend_q | irqEvent;
            // second half of rotate or stop: parameter write one cycle after
            // the mode select, kept off the sequencer so a dispatch cannot drop it
            paramWr_q <= velModeSel_q;
            if (frameDone_q && fAddr_q == moduleAddr) begin
                replyValid_q <= 1'b1;
                replyValue_q <= fVal_q;
                replyStatus_q <= `MCI_ST_OK;
                if (sum_q != fSum_q) begin
                    replyStatus_q <= `MCI_ST_BADSUM;
                end else begin
                    case (fOp_q)
                        `MCI_OP_ROTR, `MCI_OP_ROTL: begin
                            velModeSel_q <= 1'b1;
                            dirPositive_q <= (fOp_q == `MCI_OP_ROTR);
                            paramNum_q <= `MCI_PARAM_TVEL;
                            paramVal_q <= fVal_q;
                        end
                        `MCI_OP_STOP: begin
                            velModeSel_q <= 1'b1;
                            paramNum_q <= `MCI_PARAM_TSPD;
                            paramVal_q <= 32'h00000000;
                        end
                        `MCI_OP_SET_GLOBAL: begin
                            if (fBank_q == `MCI_BANK_IRQ) begin
                                cfgWr_q <= 1'b1;
                                cfgIrq_q <= fType_q;
                                cfgVal_q <= fVal_q;
                            end
                        end
                        `MCI_OP_IRQ_EN, `MCI_OP_DI: begin
                            if (fType_q == `MCI_IRQ_GLOBAL) begin
                                gEn_q <= (fOp_q == `MCI_OP_IRQ_EN);
                            end else if (valid_irq(fType_q)) begin
                                en_q[fType_q[5:0]] <= (fOp_q == `MCI_OP_IRQ_EN);
                            end else begin
                                replyStatus_q <= `MCI_ST_BADCMD;
                            end
                        end
                        `MCI_OP_HANDLER_ADDR: begin
                            if (valid_irq(fType_q)) begin
                                vecOk_q[fType_q[5:0]] <= 1'b1;
                            end else begin
                                replyStatus_q <= `MCI_ST_BADCMD;
                            end
                        end
                        `MCI_OP_HANDLER_RET: begin
                            if (inHandler_q) begin
                                inHandler_q <= 1'b0;
                                irqReturn_q <= 1'b1;
                                accOut_q <= sAcc_q;
                                xOut_q <= sX_q;
                                flagsOut_q <= sFlags_q;
                                pcOut_q <= sPc_q;
                            end
                        end
                        default: replyStatus_q <= `MCI_ST_BADCMD;
                    endcase
                end
            end
            // interrupt dispatch: no nesting while in a handler
            if (st_q == S_IDLE && !inHandler_q && gEn_q && anyReady
                && !(frameDone_q && fOp_q == `MCI_OP_HANDLER_ADDR)) begin
                sel_q <= pick;
                st_q <= S_ARM;
            end else if (st_q == S_ARM) begin
                st_q <= S_FIRE; // vector read settles
            end else if (st_q == S_FIRE) begin
                irqEnter_q <= 1'b1;
                irqVector_q <= vecData;
                inHandler_q <= 1'b1;
                sAcc_q <= accIn;
                sX_q <= xIn;
                sFlags_q <= flagsIn;
                sPc_q <= pcIn;
                pend_q <= (pend_q & ~({{(NIRQ-1){1'b0}}, 1'b1} << sel_q)) | irqEvent;
                st_q <= S_IDLE;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/mci_host_model.sv
// host side that sends binary command frames
`timescale 1ns/1ns
`default_nettype none
module mci_host_model (
    input  wire logic       ref_clk,
    output var  logic       rxValid,
    output var  logic [7:0] rxByte
);
    initial begin
        rxValid = 1'b0;
        rxByte  = 8'h00;
    end
    // nine bytes, value msb first, sum trailer, optionally spoilt
    task automatic sendFrame(input logic [7:0] ad, op, ty, bk,
                             input logic [31:0] v, input logic bad);
        logic [7:0] f [0:8];
        integer     i;
        f = '{ad, op, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
        for (i = 0; i < 8; i = i + 1)
            f[8] = f[8] + f[i];
        if (bad) f[8] = ~f[8];
        for (i = 0; i < 9; i = i + 1) begin
            @(posedge ref_clk);
            rxValid <= 1'b1;
            rxByte  <= f[i];
        end
        @(posedge ref_clk);
        rxValid <= 1'b0;
        rxByte  <= ~f[8]; // idle line never repeats the last byte
    endtask
endmodule
`default_nettype wire

// File: tb/mci_top_chk.sv
// port assertions for the command interpreter
`timescale 1ns/1ns
`default_nettype none
`include "mci_consts.vh"
module mci_top_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        velModeSel_q,
    input wire logic        paramWr_q,
    input wire logic [7:0]  paramNum_q,
    input wire logic [31:0] paramVal_q,
    input wire logic        replyValid_q,
    input wire logic [7:0]  replyStatus_q,
    input wire logic [31:0] replyValue_q,
    input wire logic        irqEnter_q,
    input wire logic        irqReturn_q,
    input wire logic        inHandler_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_MODE_THEN_PARAM: assert property (velModeSel_q |=> paramWr_q)
        else $error("param write missing after mode select");
    AST_PARAM_NEEDS_MODE: assert property (paramWr_q |-> $past(velModeSel_q))
        else $error("param write without mode select");
    AST_MODE_REPLY_OK: assert property (velModeSel_q |-> replyValid_q && replyStatus_q == `MCI_ST_OK)
        else $error("motion reply not ok");
    AST_STOP_ZERO: assert property (paramWr_q && paramNum_q == `MCI_PARAM_TSPD |-> paramVal_q == 32'h0)
        else $error("stop speed not zero");
    AST_ROT_VALUE: assert property (paramWr_q && paramNum_q == `MCI_PARAM_TVEL |-> paramVal_q == replyValue_q)
        else $error("velocity differs from frame value");
    AST_PARAM_NUM: assert property (paramWr_q |-> paramNum_q inside {`MCI_PARAM_TVEL, `MCI_PARAM_TSPD})
        else $error("bad axis parameter number");
    AST_NO_NEST: assert property (irqEnter_q |-> inHandler_q && !$past(inHandler_q))
        else $error("handler entered while in handler");
    AST_RETURN_OK: assert property (irqReturn_q |-> replyValid_q ##1 !inHandler_q)
        else $error("return did not leave handler");
    AST_REPLY_SPACING: assert property (replyValid_q |=> !replyValid_q [*8])
        else $error("replies closer than a frame");
    cover property (paramWr_q && paramNum_q == `MCI_PARAM_TVEL);
    cover property (paramWr_q && paramNum_q == `MCI_PARAM_TSPD);
    cover property (irqEnter_q);
    cover property (irqReturn_q);
endmodule
bind mci_top mci_top_chk chkU (.ref_clk, .rst, .velModeSel_q, .paramWr_q, .paramNum_q,
    .paramVal_q, .replyValid_q, .replyStatus_q, .replyValue_q, .irqEnter_q, .irqReturn_q,
    .inHandler_q);
`default_nettype wire

// File: tb/mci_top_tb.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ns
`default_nettype none
`include "mci_consts.vh"
module mci_top_tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [41:0] irqEvent = 42'h0;
    logic [31:0] accIn = 32'hA5A50001;
    logic [31:0] xIn = 32'h0000BEEF;
    logic [7:0]  flagsIn = 8'h5A;
    logic [31:0] pcIn = 32'h00000042;
    logic [7:0]  moduleAddr = `MCI_ADDR_RESET;
    logic        rxValid;
    logic [7:0]  rxByte;
    logic [7:0]  lastSt;
    wire         velModeSel_q, paramWr_q, dirPositive_q, replyValid_q;
    wire         irqEnter_q, irqReturn_q, inHandler_q, cfgWr_q;
    wire  [7:0]  paramNum_q, replyStatus_q, flagsOut_q, cfgIrq_q;
    wire  [31:0] paramVal_q, replyValue_q, irqVector_q, accOut_q, xOut_q, pcOut_q, cfgVal_q;
    integer      failures = 0, checks_done = 0, cyc = 0, nRep = 0, nPw = 0, nEnt = 0;
    integer      nCfg = 0, nRet = 0;
    mci_host_model hostU (.ref_clk, .rxValid, .rxByte);
    mci_top dut_u (.ref_clk, .rst, .rxValid, .rxByte, .moduleAddr, .irqEvent, .accIn, .xIn,
        .flagsIn, .pcIn, .velModeSel_q, .paramWr_q, .paramNum_q, .paramVal_q, .dirPositive_q,
        .replyValid_q, .replyStatus_q, .replyValue_q, .irqEnter_q, .irqVector_q, .irqReturn_q,
        .accOut_q, .xOut_q, .flagsOut_q, .pcOut_q, .inHandler_q, .cfgWr_q, .cfgIrq_q, .cfgVal_q);
    always #50 ref_clk = ~ref_clk;
    // count pulses, keep last status, cut a hang short
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (replyValid_q === 1'b1) begin
            nRep = nRep + 1;
            lastSt = replyStatus_q;
        end
        if (paramWr_q === 1'b1) nPw = nPw + 1;
        if (irqEnter_q === 1'b1) nEnt = nEnt + 1;
        if (cfgWr_q === 1'b1) nCfg = nCfg + 1;
        if (irqReturn_q === 1'b1) nRet = nRet + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one frame to our address, then let reply and writes land
    task automatic go(input logic [7:0] op, ty, bk, input logic [31:0] v, input logic bad);
        hostU.sendFrame(`MCI_ADDR_RESET, op, ty, bk, v, bad);
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("dirReset", 32'h1, dirPositive_q);
        go(`MCI_OP_ROTL, 8'h00, 8'h00, 32'h80000000, 1'b0);
        chk("dirLeft", 32'h0, dirPositive_q);
        chk("minVel", 32'h80000000, paramVal_q);
        go(`MCI_OP_ROTR, 8'h00, 8'h00, 32'h0000C800, 1'b0);
        chk("status", `MCI_ST_OK, lastSt);
        chk("dirRight", 32'h1, dirPositive_q);
        chk("pps", 32'h0000C800, paramVal_q);
        chk("velParam", `MCI_PARAM_TVEL, paramNum_q);
        go(`MCI_OP_ROTR, 8'h00, 8'h00, 32'h7FFFFFFF, 1'b0);
        chk("maxVel", 32'h7FFFFFFF, paramVal_q);
        go(`MCI_OP_STOP, 8'h00, 8'h00, 32'h0, 1'b0);
        chk("stopParam", `MCI_PARAM_TSPD, paramNum_q);
        chk("stopVal", 32'h0, paramVal_q);
        go(`MCI_OP_ROTL, 8'h00, 8'h00, 32'h00000010, 1'b1);
        chk("badSum", `MCI_ST_BADSUM, lastSt);
        chk("writes", 32'h4, nPw);
        hostU.sendFrame(8'h02, `MCI_OP_ROTR, 8'h00, 8'h00, 32'h1, 1'b0);
        repeat (6) @(posedge ref_clk);
        chk("replies", 32'h5, nRep);
        go(`MCI_OP_HANDLER_ADDR, 8'h00, 8'h00, 32'h00000100, 1'b0);
        go(`MCI_OP_SET_GLOBAL, 8'h00, `MCI_BANK_IRQ, 32'h000003E8, 1'b0);
        chk("cfgIrq", 32'h0, cfgIrq_q);
        chk("cfgVal", 32'h000003E8, cfgVal_q);
        chk("cfgWrites", 32'h1, nCfg);
        go(`MCI_OP_IRQ_EN, 8'h00, 8'h00, 32'h0, 1'b0);
        irqEvent <= 42'h1;
        @(posedge ref_clk);
        irqEvent <= 42'h0;
        repeat (6) @(posedge ref_clk);
        chk("noGlobal", 32'h0, nEnt);
        go(`MCI_OP_IRQ_EN, `MCI_IRQ_GLOBAL, 8'h00, 32'h0, 1'b0);
        chk("entered", 32'h1, nEnt);
        chk("vector", 32'h00000100, irqVector_q);
        accIn <= 32'h00000000;
        irqEvent <= 42'h1;
        @(posedge ref_clk);
        irqEvent <= 42'h0;
        repeat (6) @(posedge ref_clk);
        chk("nesting", 32'h1, nEnt);
        go(`MCI_OP_HANDLER_RET, 8'h00, 8'h00, 32'h0, 1'b0);
        chk("accBack", 32'hA5A50001, accOut_q);
        chk("xBack", 32'h0000BEEF, xOut_q);
        chk("flagsBack", 32'h5A, flagsOut_q);
        chk("pcBack", 32'h00000042, pcOut_q);
        chk("pendingKept", 32'h2, nEnt);
        // leave the second handler, then main flow runs outside it
        go(`MCI_OP_HANDLER_RET, 8'h00, 8'h00, 32'h0, 1'b0);
        chk("resumeMain", 32'h0, inHandler_q);
        chk("returns", 32'h2, nRet);
        // global disable holds a pending source off
        go(`MCI_OP_DI, `MCI_IRQ_GLOBAL, 8'h00, 32'h0, 1'b0);
        irqEvent <= 42'h1;
        @(posedge ref_clk);
        irqEvent <= 42'h0;
        repeat (6) @(posedge ref_clk);
        chk("globalOff", 32'h2, nEnt);
        // return outside a handler is answered but does nothing
        go(`MCI_OP_HANDLER_RET, 8'h00, 8'h00, 32'h0, 1'b0);
        chk("idleReturn", 32'h2, nRet);
        chk("idleRetSt", `MCI_ST_OK, lastSt);
        // unimplemented irq number is refused
        go(`MCI_OP_IRQ_EN, 8'h05, 8'h00, 32'h0, 1'b0);
        chk("badIrq", `MCI_ST_BADCMD, lastSt);
        report_and_stop;
    end
endmodule
`default_nettype wire
